// >>> cgr_host.sv
// Purpose: Host model that issues byte accesses to the register bank
// Assumes: Called just after a rising edge of sys_clk
// Notes: Each access ends one edge after the strobe is dropped
`timescale 1ns/1ps
module cgr_host (
	input wire logic sys_clk, // Device clock
	output cgr_pkg::cgr_req_t req, // Request to the bank
	input wire logic [7:0] rdata, // Read data
	input wire logic rvalid // Read data valid
);
	initial req = '0;
	// Write one byte; reserved places only ever get zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		req <= '0;
		@(posedge sys_clk);
	endtask : wr
	// Read one byte; data is taken at the edge where rvalid stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
			output logic v);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		req <= '0;
		@(posedge sys_clk);
		d = rdata;
		v = rvalid;
	endtask : rd
endmodule : cgr_host

// >>> cgr_pin_cell.sv
// Purpose: One general-purpose pin: enable, direction and drive
// Assumes: Pad input already synchronous to sys_clk
// Notes: Three-signal pad, enable high while driving
`timescale 1ns/1ps
module cgr_pin_cell (
	input wire logic digital_sel, // Function bit, one = digital
	input wire logic is_input, // Direction bit, one = input
	input wire logic out_level, // Level to drive
	output logic pad_out, // Pad output value
	output logic pad_oe, // Pad output enable
	output logic pin_usable // Pin enabled for digital use
);
	// Drive only in digital output mode; analog pins stay quiet
	always_comb begin
		pin_usable = digital_sel;
		pad_oe = digital_sel & ~is_input;
		pad_out = out_level & pad_oe;
	end
endmodule : cgr_pin_cell

// >>> cgr_pkg.sv
// Purpose: Constants and types for the trim and pin register bank
// Assumes: Byte-wide register port inside the device, one clock
// Notes: Offsets are the printed register addresses
//
// Summary of operation
// - Offset trim is 16 bits: low byte at 0Bh, high at 0Ch, both reset 00h.
// - Gain trim is 16 bits: low byte at 0Eh reset 00h, high at 0Fh reset 40h.
// - Reserved 0Ah and 0Dh read zero, ignore writes; host writes only zero.
// - Upper four pin data bits set direction: zero output, one input.
// - Lower four pin data bits hold pin levels: drive outputs, reflect inputs.
// - Function bit x: 0 analog, 1 digital pin; upper four bits read zero.
// - All four pins stay disabled from reset until their function bit is set.
package cgr_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RSVD_0A = 8'h0a;
	localparam logic [7:0] ADDR_OFS_LO = 8'h0b;
	localparam logic [7:0] ADDR_OFS_HI = 8'h0c;
	localparam logic [7:0] ADDR_RSVD_0D = 8'h0d;
	localparam logic [7:0] ADDR_GAIN_LO = 8'h0e;
	localparam logic [7:0] ADDR_GAIN_HI = 8'h0f;
	localparam logic [7:0] ADDR_PIN_LVL = 8'h10;
	localparam logic [7:0] ADDR_PIN_FN = 8'h11;
	// ----------------------------------------------------------------
	// Reset values and widths
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_OFS_LO = 8'h00;
	localparam logic [7:0] RST_OFS_HI = 8'h00;
	localparam logic [7:0] RST_GAIN_LO = 8'h00;
	localparam logic [7:0] RST_GAIN_HI = 8'h40;
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int PIN_COUNT = 4;
	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cgr_req_t;
	typedef struct packed {
		logic [3:0] way;
		logic [3:0] level;
	} cgr_pin_byte_t;
endpackage : cgr_pkg

// >>> cgr_regs.sv
// Purpose: Trim and general-purpose pin register bank
// Assumes: Host interface delivers one-cycle byte read/write strobes
// Notes: Read data registered, valid the cycle after rd_en
`timescale 1ns/1ps
module cgr_regs (
	input wire logic sys_clk, // Device clock, 100 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire cgr_pkg::cgr_req_t req, // Register access request
	output logic [7:0] rdata, // Read data, registered
	output logic rvalid, // Read data valid pulse
	output logic [15:0] offset_trim_value, // Offset correction
	output logic [15:0] gain_trim_value, // Gain correction
	input wire logic [3:0] pin_in, // Pad input levels
	output logic [3:0] pin_out, // Pad output levels
	output logic [3:0] pin_oe, // Pad output enables
	output logic [3:0] pin_usable // Pins enabled as digital
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ofs_lo_reg, ofs_lo_next;
	logic [7:0] ofs_hi_reg, ofs_hi_next;
	logic [7:0] gain_lo_reg, gain_lo_next;
	logic [7:0] gain_hi_reg, gain_hi_next;
	logic [3:0] way_reg, way_next;
	logic [3:0] level_reg, level_next;
	logic [3:0] role_reg, role_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [3:0] pin_level_bits;
	cgr_pkg::cgr_pin_byte_t pin_byte;

	// Level readback: input pins reflect the pad, others the stored bit
	always_comb begin
		pin_level_bits = (level_reg & ~way_reg) | (pin_in & way_reg);
		pin_byte.way = way_reg;
		pin_byte.level = pin_level_bits;
	end

	// Write decode and read mux
	always_comb begin
		ofs_lo_next = ofs_lo_reg;
		ofs_hi_next = ofs_hi_reg;
		gain_lo_next = gain_lo_reg;
		gain_hi_next = gain_hi_reg;
		way_next = way_reg;
		level_next = level_reg;
		role_next = role_reg;
		rvalid_next = req.rd_en;
		rdata_next = rdata_reg;
		if (req.wr_en) begin
			case (req.addr)
				cgr_pkg::ADDR_OFS_LO: ofs_lo_next = req.wdata;
				cgr_pkg::ADDR_OFS_HI: ofs_hi_next = req.wdata;
				cgr_pkg::ADDR_GAIN_LO: gain_lo_next = req.wdata;
				cgr_pkg::ADDR_GAIN_HI: gain_hi_next = req.wdata;
				cgr_pkg::ADDR_PIN_LVL: begin
					way_next = req.wdata[7:4];
					level_next = req.wdata[3:0];
				end
				cgr_pkg::ADDR_PIN_FN: role_next = req.wdata[3:0];
				default: role_next = role_reg;
			endcase
		end
		if (req.rd_en) begin
			case (req.addr)
				cgr_pkg::ADDR_OFS_LO: rdata_next = ofs_lo_reg;
				cgr_pkg::ADDR_OFS_HI: rdata_next = ofs_hi_reg;
				cgr_pkg::ADDR_GAIN_LO: rdata_next = gain_lo_reg;
				cgr_pkg::ADDR_GAIN_HI: rdata_next = gain_hi_reg;
				cgr_pkg::ADDR_PIN_LVL: rdata_next = pin_byte;
				cgr_pkg::ADDR_PIN_FN: rdata_next = {cgr_pkg::RST_NIBBLE, role_reg};
				default: rdata_next = cgr_pkg::READ_ZERO;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ofs_lo_reg <= cgr_pkg::RST_OFS_LO;
			ofs_hi_reg <= cgr_pkg::RST_OFS_HI;
			gain_lo_reg <= cgr_pkg::RST_GAIN_LO;
			gain_hi_reg <= cgr_pkg::RST_GAIN_HI;
			way_reg <= cgr_pkg::RST_NIBBLE;
			level_reg <= cgr_pkg::RST_NIBBLE;
			role_reg <= cgr_pkg::RST_NIBBLE;
			rdata_reg <= cgr_pkg::READ_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			ofs_lo_reg <= ofs_lo_next;
			ofs_hi_reg <= ofs_hi_next;
			gain_lo_reg <= gain_lo_next;
			gain_hi_reg <= gain_hi_next;
			way_reg <= way_next;
			level_reg <= level_next;
			role_reg <= role_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Outputs
	always_comb begin
		rdata = rdata_reg;
		rvalid = rvalid_reg;
		offset_trim_value = {ofs_hi_reg, ofs_lo_reg};
		gain_trim_value = {gain_hi_reg, gain_lo_reg};
	end

	// ----------------------------------------------------------------
	// Pin cells
	// ----------------------------------------------------------------
	for (genvar i = 0; i < cgr_pkg::PIN_COUNT; i++) begin : g_pin
		cgr_pin_cell u_cell (
			.digital_sel(role_reg[i]),
			.is_input(way_reg[i]),
			.out_level(level_reg[i]),
			.pad_out(pin_out[i]),
			.pad_oe(pin_oe[i]),
			.pin_usable(pin_usable[i])
		);
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Trim bytes: each write lands in its own half, reads return it
	a_offset_write: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && req.addr == cgr_pkg::ADDR_OFS_HI |=>
		offset_trim_value[15:8] == $past(req.wdata))
		else $error("Offset high byte not stored");
	a_offset_low: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && req.addr == cgr_pkg::ADDR_OFS_LO |=>
		offset_trim_value[7:0] == $past(req.wdata))
		else $error("Offset low byte not stored");
	a_offset_read: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.rd_en && req.addr == cgr_pkg::ADDR_OFS_LO |=>
		rvalid && rdata == $past(offset_trim_value[7:0]))
		else $error("Offset low byte readback wrong");
	a_gain_write: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && req.addr == cgr_pkg::ADDR_GAIN_LO |=>
		gain_trim_value[7:0] == $past(req.wdata))
		else $error("Gain low byte not stored");
	a_gain_high: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && req.addr == cgr_pkg::ADDR_GAIN_HI |=>
		gain_trim_value[15:8] == $past(req.wdata))
		else $error("Gain high byte not stored");
	a_gain_read: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.rd_en && req.addr == cgr_pkg::ADDR_GAIN_HI |=>
		rvalid && rdata == $past(gain_trim_value[15:8]))
		else $error("Gain high byte readback wrong");
	// Reserved locations: read zero and leave all state alone
	a_rsvd_read: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.rd_en && (req.addr == cgr_pkg::ADDR_RSVD_0A ||
		req.addr == cgr_pkg::ADDR_RSVD_0D) |=>
		rvalid && rdata == cgr_pkg::READ_ZERO)
		else $error("Reserved location read nonzero");
	a_rsvd_write: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && (req.addr == cgr_pkg::ADDR_RSVD_0A ||
		req.addr == cgr_pkg::ADDR_RSVD_0D) |=>
		$stable(offset_trim_value) && $stable(gain_trim_value) &&
		$stable(pin_oe) && $stable(pin_usable))
		else $error("Reserved write changed state");
	// Pin control: direction, level, function and drive
	a_dir_input: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && req.addr == cgr_pkg::ADDR_PIN_LVL && req.wdata[4] |=>
		!pin_oe[0])
		else $error("Input pin still driven");
	a_input_quiet: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		way_reg[0] |-> !pin_oe[0])
		else $error("Input-direction pin driven");
	a_out_enable: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		role_reg[3] && !way_reg[3] |-> pin_oe[3])
		else $error("Digital output pin not driven");
	a_dir_read: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.rd_en && req.addr == cgr_pkg::ADDR_PIN_LVL |=>
		rdata[7:4] == $past(way_reg))
		else $error("Direction bits readback wrong");
	a_drive_level: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		pin_oe[1] |-> pin_out[1] == level_reg[1])
		else $error("Output pin level differs from data bit");
	a_level_input: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.rd_en && req.addr == cgr_pkg::ADDR_PIN_LVL && way_reg[0] |=>
		rdata[0] == $past(pin_in[0]))
		else $error("Input pin level not reflected");
	a_fn_upper: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.rd_en && req.addr == cgr_pkg::ADDR_PIN_FN |=>
		rdata[7:4] == cgr_pkg::RST_NIBBLE && rdata[3:0] == $past(role_reg))
		else $error("Function select readback wrong");
	a_enable_follows: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		req.wr_en && req.addr == cgr_pkg::ADDR_PIN_FN |=>
		pin_usable == $past(req.wdata[3:0]))
		else $error("Pin enable does not follow function bits");
	a_usable_gate: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!pin_usable[1] |-> !pin_oe[1])
		else $error("Disabled pin driven");
	a_analog_quiet: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!role_reg[2] |-> !pin_oe[2] && !pin_out[2])
		else $error("Analog pin driven");
	a_analog_all: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!(|(pin_oe & ~role_reg)))
		else $error("Some analog pin has its enable high");
	a_idle_low: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!pin_oe[0] |-> !pin_out[0])
		else $error("Undriven pin shows a drive level");
endmodule : cgr_regs

// >>> cgr_regs_test.sv
// Purpose: Self-checking test of the trim and pin register bank
// Assumes: Host model issues every register access
// Notes: Pads read back their own drive, else the external level
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module cgr_regs_test;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] ext_lvl = 4'ha;
	logic [3:0] pin_in, pin_out, pin_oe, pin_usable;
	logic [7:0] rdata, d;
	logic rvalid, v;
	logic [15:0] ofs, gain;
	cgr_pkg::cgr_req_t req;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
		8'h00, 8'h00};
	always #5 sys_clk = ~sys_clk;
	// Pad model: driven pins show their drive
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	cgr_regs cgr_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
		.rdata(rdata), .rvalid(rvalid), .offset_trim_value(ofs),
		.gain_trim_value(gain), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_usable(pin_usable));
	cgr_host cgr_host_inst (.sys_clk(sys_clk), .req(req), .rdata(rdata),
		.rvalid(rvalid));
	// Read and compare one byte
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		cgr_host_inst.rd(a, d, v);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask : rd_chk
	task automatic report_and_stop();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		// Reset values of every location
		for (int i = 0; i < 8; i++) rd_chk(8'h0a + i[7:0], rst_tab[i]);
		`CHK(gain, 16'h4000)
		`CHK(pin_usable, 4'h0)
		$display("test reset done");
		// Byte halves land apart; reserved and upper nibble stay zero
		cgr_host_inst.wr(8'h0b, 8'ha5);
		cgr_host_inst.wr(8'h0c, 8'h5a);
		cgr_host_inst.wr(8'h0e, 8'h3c);
		cgr_host_inst.wr(8'h0f, 8'hc3);
		cgr_host_inst.wr(8'h0a, 8'h00);
		cgr_host_inst.wr(8'h0d, 8'h00);
		cgr_host_inst.wr(8'h11, 8'h0f);
		`CHK(ofs, 16'h5aa5)
		`CHK(gain, 16'hc33c)
		rd_chk(8'h0a, 8'h00);
		rd_chk(8'h0d, 8'h00);
		rd_chk(8'h0f, 8'hc3);
		rd_chk(8'h11, 8'h0f);
		$display("test trim done");
		// Pins 0,1 inputs, 2,3 outputs
		cgr_host_inst.wr(8'h10, 8'h35);
		`CHK(pin_oe, 4'hc)
		`CHK(pin_out & pin_oe, 4'h4)
		rd_chk(8'h10, 8'h36);
		// Analog pins are never driven
		cgr_host_inst.wr(8'h11, 8'h05);
		`CHK(pin_usable, 4'h5)
		`CHK(pin_oe, 4'h4)
		cgr_host_inst.wr(8'h11, 8'h00);
		`CHK(pin_oe, 4'h0)
		$display("test pins done");
		// Mid-run reset brings every register back to its default
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		`CHK(ofs, 16'h0000)
		`CHK(gain, 16'h4000)
		`CHK(pin_usable, 4'h0)
		`CHK(pin_oe, 4'h0)
		rd_chk(8'h10, 8'h00);
		$display("test reset again done");
		report_and_stop();
	end
endmodule : cgr_regs_test
